// ===== verilog/ppdc_pkg.sv
// Package: register map, field positions, reset values and timing counts of the port control block
package ppdc_pkg;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] PPDC_OFS_CTRL   = 8'h00;  // interface_control
  localparam logic [7:0] PPDC_OFS_STATUS = 8'h04;  // interface_event_status
  localparam logic [7:0] PPDC_OFS_INIT   = 8'h08;  // dma_init_constant
  localparam logic [7:0] PPDC_OFS_CFG    = 8'h0C;  // port_config

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PPDC_CTL_START   = 7;
  localparam int PPDC_CTL_CLR_EOD = 6;
  localparam int PPDC_CTL_TC_EN   = 5;
  localparam int PPDC_CTL_SEL_EN  = 4;
  localparam int PPDC_CTL_ERR_EN  = 3;
  localparam int PPDC_CTL_PE_EN   = 2;
  localparam int PPDC_CTL_SET_EOD = 1;
  localparam int PPDC_CTL_DMA_EN  = 0;
  localparam int PPDC_STS_EOD     = 6;
  localparam int PPDC_CFG_EXT     = 0;

  // ==========================================================================
  // DMA command codes on control bits 7,6,1,0
  // ==========================================================================
  localparam logic [3:0] PPDC_CMD_NOCHG = 4'h1;
  localparam logic [3:0] PPDC_CMD_DIS   = 4'h2;
  localparam logic [3:0] PPDC_CMD_HALT  = 4'h3;
  localparam logic [3:0] PPDC_CMD_ARMRX = 4'h5;
  localparam logic [3:0] PPDC_CMD_SEND  = 4'h9;

  // ==========================================================================
  // Reset values and constants
  // ==========================================================================
  localparam logic [7:0] PPDC_INIT_KEY   = 8'h16;
  localparam logic [3:0] PPDC_EN_RST     = 4'h0;
  localparam logic [3:0] PPDC_FLAG_RST   = 4'h0;
  localparam logic [7:0] PPDC_BYTE_RST   = 8'h00;
  localparam logic [7:0] PPDC_ALL_ONES   = 8'hFF;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int PPDC_CLK_PERIOD_NS = 10;
  localparam int PPDC_STB_TIME_NS   = 1000;  // setup and strobe width, 1.0 us +/- 0.25 us
  localparam logic [7:0] PPDC_STB_CYCLES = 8'(PPDC_STB_TIME_NS / PPDC_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    PPDC_IDLE   = 3'b000,
    PPDC_S_REQ  = 3'b001,
    PPDC_S_SET  = 3'b010,
    PPDC_S_STB  = 3'b011,
    PPDC_S_WACK = 3'b100,
    PPDC_R_WAIT = 3'b101,
    PPDC_R_STB  = 3'b110,
    PPDC_R_REQ  = 3'b111
  } ppdc_state_t;

endpackage : ppdc_pkg

// ===== verilog/ppdc_top.sv
// Extended-mode DMA, event flag and auto-strobe control of a host printer port
module ppdc_top
  import ppdc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ_O,
  output logic             DMA_REQ_O,
  input  wire logic        DMA_ACK_I,
  input  wire logic        DMA_TC_I,
  input  wire logic [7:0]  DMA_DAT_I,
  output logic      [7:0]  DMA_DAT_O,
  input  wire logic [7:0]  PD_I,
  output logic      [7:0]  PD_O,
  output logic             PD_OE,
  output logic             STROBE_N_O,
  output logic             STROBE_N_OE,
  input  wire logic        ACK_N_I,
  input  wire logic        PRINTER_SELECTED_I,
  input  wire logic        ERROR_N_I,
  input  wire logic        PAPER_OUT_I
);

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        req_new;
  logic        wr_fire;
  logic        rd_fire;
  logic        ctl_wr;
  logic [7:0]  wb;
  logic [3:0]  cmd;

  assign req_new = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wr_fire = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I;
  assign rd_fire = WB_CYC_I & WB_STB_I & ack_q & ~WB_WE_I;
  assign wb      = WB_DAT_I[7:0];
  assign ctl_wr  = wr_fire & WB_SEL_I[0] & (WB_ADR_I == PPDC_OFS_CTRL);
  assign cmd     = {wb[PPDC_CTL_START], wb[PPDC_CTL_CLR_EOD], wb[PPDC_CTL_SET_EOD], wb[PPDC_CTL_DMA_EN]};

  // ==========================================================================
  // Control state
  // ==========================================================================
  logic        ext_q;
  logic        dma_en_q;
  logic [3:0]  en_q;      // [3]=count/ack, [2]=select, [1]=error, [0]=paper-out
  logic [3:0]  flag_q;
  logic        eod_q;
  logic [7:0]  init_q;
  logic        init_ok;
  logic        cmd_send;
  logic        cmd_armrx;
  logic        cmd_set_eod;
  logic        cmd_clr_eod;
  logic        tc_evt;
  logic        ack_rise;
  logic        ack_fall;
  logic        ack_n_q;
  logic        sel_q;
  logic        err_q;
  logic        pe_q;
  logic [3:0]  evt;
  ppdc_state_t st_q;
  logic [7:0]  cnt_q;
  logic        cnt_done;

  assign init_ok     = (init_q == PPDC_INIT_KEY);
  assign cmd_send    = ctl_wr & (cmd == PPDC_CMD_SEND);
  assign cmd_armrx   = ctl_wr & (cmd == PPDC_CMD_ARMRX);
  assign cmd_set_eod = ctl_wr & ((cmd == PPDC_CMD_DIS) | (cmd == PPDC_CMD_HALT));
  assign cmd_clr_eod = cmd_armrx;
  assign tc_evt      = DMA_ACK_I & DMA_TC_I & dma_en_q &
                       ((st_q == PPDC_S_REQ) | (st_q == PPDC_R_REQ));
  assign ack_rise    = ~ack_n_q & ACK_N_I;
  assign ack_fall    = ack_n_q & ~ACK_N_I;
  assign cnt_done    = (cnt_q == PPDC_STB_CYCLES - 8'h01);

  // Hardware events per flag; flags only count in extended mode
  assign evt[3] = dma_en_q & (tc_evt | (ack_rise & eod_q));
  assign evt[2] = PRINTER_SELECTED_I ^ sel_q;
  assign evt[1] = ERROR_N_I ^ err_q;
  assign evt[0] = PAPER_OUT_I ^ pe_q;

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_new;
      if (req_new) begin
        case (WB_ADR_I)
          PPDC_OFS_CTRL:   rdat_q <= {24'h000000, ext_q ?
                                      {2'b11, en_q, 1'b1, dma_en_q} : PPDC_ALL_ONES};
          PPDC_OFS_STATUS: rdat_q <= {24'h000000, ext_q ?
                                      {1'b1, eod_q, flag_q, 2'b11} : PPDC_ALL_ONES};
          PPDC_OFS_CFG:    rdat_q <= {24'h000000, 1'b0, st_q, 1'b0, init_ok, 1'b0, ext_q};
          default:         rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ==========================================================================
  // Configuration and init registers
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ext_q  <= 1'b0;
      init_q <= PPDC_BYTE_RST;
    end else begin
      if (wr_fire & WB_SEL_I[0] & (WB_ADR_I == PPDC_OFS_CFG)) begin
        ext_q <= wb[PPDC_CFG_EXT];
      end
      if (wr_fire & WB_SEL_I[0] & (WB_ADR_I == PPDC_OFS_INIT)) begin
        init_q <= wb;
      end
    end
  end

  // ==========================================================================
  // Interface control: enables and DMA enable
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      en_q     <= PPDC_EN_RST;
      dma_en_q <= 1'b0;
    end else if (ctl_wr) begin
      en_q <= wb[PPDC_CTL_TC_EN:PPDC_CTL_PE_EN];
      case (cmd)
        PPDC_CMD_DIS:   dma_en_q <= 1'b0;
        PPDC_CMD_HALT:  dma_en_q <= 1'b1;
        PPDC_CMD_ARMRX: dma_en_q <= 1'b1;
        default:        dma_en_q <= dma_en_q;
      endcase
    end
  end

  // ==========================================================================
  // End-of-data latch: set beats clear
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      eod_q <= 1'b1;
    end else if (tc_evt | cmd_set_eod) begin
      eod_q <= 1'b1;
    end else if (cmd_clr_eod) begin
      eod_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Event flags
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ack_n_q <= 1'b1;
      sel_q   <= 1'b0;
      err_q   <= 1'b1;
      pe_q    <= 1'b0;
    end else begin
      ack_n_q <= ACK_N_I;
      sel_q   <= PRINTER_SELECTED_I;
      err_q   <= ERROR_N_I;
      pe_q    <= PAPER_OUT_I;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flag
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          flag_q[gi] <= 1'b0;
        end else if (~en_q[gi] | ~ext_q) begin
          flag_q[gi] <= 1'b0;
        end else if (evt[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (rd_fire & (WB_ADR_I == PPDC_OFS_STATUS)) begin
          flag_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(flag_q & en_q);
    end
  end

  // ==========================================================================
  // Transfer sequencer with automatic strobe timing
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q        <= PPDC_IDLE;
      cnt_q       <= 8'h00;
      DMA_REQ_O   <= 1'b0;
      DMA_DAT_O   <= PPDC_BYTE_RST;
      PD_O        <= PPDC_BYTE_RST;
      PD_OE       <= 1'b0;
      STROBE_N_O  <= 1'b1;
      STROBE_N_OE <= 1'b1;
    end else begin
      STROBE_N_OE <= 1'b1;
      case (st_q)
        PPDC_IDLE: begin
          DMA_REQ_O  <= 1'b0;
          STROBE_N_O <= 1'b1;
          cnt_q      <= 8'h00;
          if (cmd_send & dma_en_q & ~eod_q & ext_q & init_ok) begin
            st_q      <= PPDC_S_REQ;
            DMA_REQ_O <= 1'b1;
            PD_OE     <= 1'b1;
          end else if (cmd_armrx & ext_q & init_ok) begin
            st_q  <= PPDC_R_WAIT;
            PD_OE <= 1'b0;
          end
        end
        PPDC_S_REQ: begin
          if (~dma_en_q | eod_q) begin
            st_q      <= PPDC_IDLE;
            DMA_REQ_O <= 1'b0;
          end else if (DMA_ACK_I) begin
            DMA_REQ_O <= 1'b0;
            PD_O      <= DMA_DAT_I;
            cnt_q     <= 8'h00;
            st_q      <= PPDC_S_SET;
          end
        end
        PPDC_S_SET: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_done) begin
            cnt_q      <= 8'h00;
            STROBE_N_O <= 1'b0;
            st_q       <= PPDC_S_STB;
          end
        end
        PPDC_S_STB: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_done) begin
            cnt_q      <= 8'h00;
            STROBE_N_O <= 1'b1;
            st_q       <= PPDC_S_WACK;
          end
        end
        PPDC_S_WACK: begin
          if (~dma_en_q | eod_q) begin
            st_q <= PPDC_IDLE;
          end else if (ack_rise) begin
            st_q      <= PPDC_S_REQ;
            DMA_REQ_O <= 1'b1;
          end
        end
        PPDC_R_WAIT: begin
          if (~dma_en_q | eod_q) begin
            st_q <= PPDC_IDLE;
          end else if (cmd_send & ext_q & init_ok) begin
            st_q      <= PPDC_S_REQ;
            DMA_REQ_O <= 1'b1;
            PD_OE     <= 1'b1;
          end else if (ack_fall) begin
            DMA_DAT_O  <= PD_I;
            STROBE_N_O <= 1'b0;
            cnt_q      <= 8'h00;
            st_q       <= PPDC_R_STB;
          end
        end
        PPDC_R_STB: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_done) begin
            cnt_q      <= 8'h00;
            STROBE_N_O <= 1'b1;
            DMA_REQ_O  <= 1'b1;
            st_q       <= PPDC_R_REQ;
          end
        end
        PPDC_R_REQ: begin
          if (~dma_en_q) begin
            DMA_REQ_O <= 1'b0;
            st_q      <= PPDC_IDLE;
          end else if (DMA_ACK_I) begin
            DMA_REQ_O <= 1'b0;
            st_q      <= DMA_TC_I ? PPDC_IDLE : PPDC_R_WAIT;
          end
        end
        default: begin
          st_q <= PPDC_IDLE;
        end
      endcase
    end
  end

endmodule : ppdc_top

// ===== bench/ppdc_top_sva.sv
// Checker: bus, flag, interrupt and strobe timing properties of the port control block
module ppdc_chk
  import ppdc_pkg::*;
(
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        IRQ_O,
  input wire logic        DMA_ACK_I,
  input wire logic [7:0]  DMA_DAT_O,
  input wire logic [7:0]  PD_I,
  input wire logic        PD_OE,
  input wire logic        STROBE_N_O,
  input wire logic        ACK_N_I,
  input wire logic        PRINTER_SELECTED_I,
  input wire logic        ERROR_N_I,
  input wire logic        PAPER_OUT_I
);
  // ==========================================================================
  // Shadow of mode and enables, strobe counters
  logic       ext_q;
  logic [5:2] en_q;
  logic [7:0] lo_q;
  logic [7:0] gap_q;
  logic       rd_sts;
  logic       rd_ctl;
  logic       wr_ctl;
  logic [3:0] ev;
  assign rd_sts = WB_ACK_O && !WB_WE_I && WB_ADR_I == PPDC_OFS_STATUS;
  assign rd_ctl = WB_ACK_O && !WB_WE_I && WB_ADR_I == PPDC_OFS_CTRL;
  assign wr_ctl = WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == PPDC_OFS_CTRL;
  assign ev     = {PRINTER_SELECTED_I, ERROR_N_I, PAPER_OUT_I, ACK_N_I};
  always_ff @(posedge CLK) begin
    if (SYS_RST) ext_q <= 1'b0;
    else if (WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == PPDC_OFS_CFG) ext_q <= WB_DAT_I[PPDC_CFG_EXT];
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) en_q <= PPDC_EN_RST;
    else if (wr_ctl) en_q <= WB_DAT_I[5:2];
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST || STROBE_N_O) lo_q <= 8'h00;
    else if (lo_q != 8'hFF) lo_q <= lo_q + 8'h01;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) gap_q <= 8'hFF;
    else if (DMA_ACK_I && PD_OE) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_compat; rd_sts && !ext_q |-> WB_DAT_O[7:0] == PPDC_ALL_ONES; endproperty
  a_compat: assert property (p_compat) else $error("status not all ones");
  property p_ctl_ones; rd_ctl |-> WB_DAT_O[7:6] == 2'h3 && WB_DAT_O[1]; endproperty
  a_ctl_ones: assert property (p_ctl_ones) else $error("command bits not one");
  property p_sel; $changed(PRINTER_SELECTED_I) && ext_q && en_q[4] && !WB_CYC_I |-> ##[1:3] IRQ_O; endproperty
  a_sel: assert property (p_sel) else $error("select edge gave no irq");
  property p_err; $changed(ERROR_N_I) && ext_q && en_q[3] && !WB_CYC_I |-> ##[1:3] IRQ_O; endproperty
  a_err: assert property (p_err) else $error("error edge gave no irq");
  property p_pe; $changed(PAPER_OUT_I) && ext_q && en_q[2] && !WB_CYC_I |-> ##[1:3] IRQ_O; endproperty
  a_pe: assert property (p_pe) else $error("paper edge gave no irq");
  property p_irq_drop; wr_ctl && WB_DAT_I[5:2] == 4'h0 |-> ##2 !IRQ_O; endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq kept with enables off");
  property p_clr; rd_sts && ext_q && $stable(ev) && $past(ev) == $past(ev, 2) && !$past(DMA_ACK_I) |-> ##2 !IRQ_O;
  endproperty
  a_clr: assert property (p_clr) else $error("irq kept after status read");
  property p_setup; $fell(STROBE_N_O) && PD_OE |-> gap_q > 8'h4B && gap_q < 8'h7E; endproperty
  a_setup: assert property (p_setup) else $error("strobe setup out of range");
  property p_width; $rose(STROBE_N_O) |-> lo_q > 8'h4B && lo_q < 8'h7E; endproperty
  a_width: assert property (p_width) else $error("strobe width out of range");
  property p_rx; $fell(STROBE_N_O) && !PD_OE |-> DMA_DAT_O == $past(PD_I); endproperty
  a_rx: assert property (p_rx) else $error("strobe before data sampled");
endmodule : ppdc_chk

bind ppdc_top ppdc_chk u_ppdc_chk (.CLK, .SYS_RST, .WB_CYC_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
  .WB_DAT_O, .WB_ACK_O, .IRQ_O, .DMA_ACK_I, .DMA_DAT_O, .PD_I, .PD_OE, .STROBE_N_O, .ACK_N_I,
  .PRINTER_SELECTED_I, .ERROR_N_I, .PAPER_OUT_I);

// ===== bench/ppdc_prn_model.sv
// Printer model: latches each strobed byte, answers with an acknowledge pulse, supplies receive data
module ppdc_prn_model #(
  parameter logic [7:0] DLY = 8'h14
) (
  input  wire logic       clk,
  input  wire logic       strobe_n,
  input  wire logic [7:0] pd_o,
  input  wire logic       pd_oe,
  input  wire logic       kick,
  output logic            ack_n,
  output logic      [7:0] pd_i,
  output logic      [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Acknowledge after strobe end, or on command for receive
  logic       stb_q = 1'b1;
  logic [7:0] cnt_q = 8'h00;
  assign pd_i  = pd_oe ? pd_o : 8'h5C;
  assign ack_n = !(cnt_q > DLY && cnt_q <= DLY + 8'h64);
  always_ff @(posedge clk) begin
    stb_q <= strobe_n;
    if ((strobe_n && !stb_q) || kick) begin
      cnt_q <= 8'h01;
      got   <= pd_o;
    end else if (cnt_q != 8'h00) cnt_q <= cnt_q + 8'h01;
  end
endmodule : ppdc_prn_model

// ===== bench/ppdc_top_bench.sv
// Testbench: register access, event flags, interrupt and DMA strobe sequences of the port block
module ppdc_top_bench import ppdc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, WB_ACK_O, IRQ_O, DMA_REQ_O, PD_OE, STROBE_N_O, STROBE_N_OE, ACK_N_I;
  logic        SYS_RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0, kick = 1'b0;
  logic        DMA_ACK_I = 1'b0, DMA_TC_I = 1'b0, PRINTER_SELECTED_I = 1'b0, ERROR_N_I = 1'b1, PAPER_OUT_I = 1'b0;
  logic [7:0]  WB_ADR_I = 8'h00, DMA_DAT_I = 8'h00, DMA_DAT_O, PD_I, PD_O, got;
  logic [3:0]  WB_SEL_I = 4'hF;
  logic [31:0] WB_DAT_I = 32'h00000000, WB_DAT_O;
  int          err_count = 0, compares = 0;
  logic [7:0]  cmd [6] = '{8'h03, 8'h01, 8'h02, 8'h01, 8'h41, 8'h02};
  logic [7:0]  ctl [6] = '{8'hC3, 8'hC3, 8'hC2, 8'hC2, 8'hC3, 8'hC2};
  logic [7:0]  sts [6] = '{8'hC3, 8'hC3, 8'hC3, 8'hC3, 8'h83, 8'hC3};

  ppdc_top u_ppdc_top (.CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .IRQ_O, .DMA_REQ_O, .DMA_ACK_I, .DMA_TC_I, .DMA_DAT_I, .DMA_DAT_O, .PD_I, .PD_O,
    .PD_OE, .STROBE_N_O, .STROBE_N_OE, .ACK_N_I, .PRINTER_SELECTED_I, .ERROR_N_I, .PAPER_OUT_I);
  ppdc_prn_model u_ppdc_prn_model (.clk(CLK), .strobe_n(STROBE_N_O), .pd_o(PD_O), .pd_oe(PD_OE),
    .kick(kick), .ack_n(ACK_N_I), .pd_i(PD_I), .got(got));

  // ==========================================================================
  // Bus, compare and event tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    if (WB_ACK_O !== 1'b1) err_count++;
    q = WB_DAT_O[7:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I  <= 1'b0;
    @(posedge CLK);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic flip(input int i);
    if (i == 0) PRINTER_SELECTED_I <= ~PRINTER_SELECTED_I;
    else if (i == 1) ERROR_N_I <= ~ERROR_N_I;
    else PAPER_OUT_I <= ~PAPER_OUT_I;
  endtask : flip
  task automatic grant(input logic [7:0] b, input logic tc);
    int n;
    n = 0;
    while (DMA_REQ_O !== 1'b1 && n < 400) begin
      @(posedge CLK);
      n++;
    end
    if (DMA_REQ_O !== 1'b1) err_count++;
    DMA_ACK_I <= 1'b1;
    DMA_DAT_I <= b;
    DMA_TC_I  <= tc;
    @(posedge CLK);
    DMA_ACK_I <= 1'b0;
    DMA_TC_I  <= 1'b0;
  endtask : grant
  task automatic strobe(output int t);
    int w;
    t = 0;
    w = 0;
    while (STROBE_N_O !== 1'b0 && t < 400) begin
      @(posedge CLK);
      t++;
    end
    while (STROBE_N_O === 1'b0 && w < 400) begin
      @(posedge CLK);
      w++;
    end
    chk(8'(w > 75 && w < 126), 8'h01);
  endtask : strobe
  task automatic wrap_up();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    repeat (20000) @(posedge CLK);
    err_count++;
    wrap_up();
  end
  initial begin
    int t;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    rd(PPDC_OFS_STATUS, PPDC_ALL_ONES);
    rd(PPDC_OFS_CTRL, PPDC_ALL_ONES);
    rd(8'h10, 8'h00);
    wr(PPDC_OFS_CFG, 8'h01);
    wr(PPDC_OFS_INIT, PPDC_INIT_KEY);
    rd(PPDC_OFS_INIT, 8'h00);
    rd(PPDC_OFS_STATUS, 8'hC3);
    for (int i = 0; i < 6; i++) begin
      wr(PPDC_OFS_CTRL, cmd[i]);
      rd(PPDC_OFS_CTRL, ctl[i]);
      rd(PPDC_OFS_STATUS, sts[i]);
    end
    wr(PPDC_OFS_CTRL, 8'h3D);
    rd(PPDC_OFS_CTRL, 8'hFE);
    for (int i = 0; i < 3; i++) begin
      flip(i);
      repeat (4) @(posedge CLK);
      chk(8'(IRQ_O), 8'h01);
      rd(PPDC_OFS_STATUS, 8'hC3 | (8'h10 >> i));
      repeat (2) @(posedge CLK);
      chk(8'(IRQ_O), 8'h00);
      flip(i);
      repeat (4) @(posedge CLK);
      wr(PPDC_OFS_CTRL, 8'h3D & ~(8'h10 >> i));
      repeat (2) @(posedge CLK);
      chk(8'(IRQ_O), 8'h00);
      rd(PPDC_OFS_STATUS, 8'hC3);
      wr(PPDC_OFS_CTRL, 8'h3D);
    end
    wr(PPDC_OFS_CTRL, 8'h61);
    kick <= 1'b1;
    @(posedge CLK);
    kick <= 1'b0;
    strobe(t);
    chk(DMA_DAT_O, 8'h5C);
    grant(8'h00, 1'b1);
    repeat (4) @(posedge CLK);
    chk(8'(IRQ_O), 8'h01);
    rd(PPDC_OFS_STATUS, 8'hE3);
    wr(PPDC_OFS_CTRL, 8'h61);
    wr(PPDC_OFS_CTRL, 8'hA1);
    grant(8'hA5, 1'b0);
    strobe(t);
    chk(8'(t > 75 && t < 127), 8'h01);
    grant(8'h3C, 1'b1);
    chk(got, 8'hA5);
    strobe(t);
    @(posedge CLK);
    chk(got, 8'h3C);
    rd(PPDC_OFS_STATUS, 8'hE3);
    wrap_up();
  end
endmodule : ppdc_top_bench
